//--- core/prs_pin_sync.sv
// two-stage synchroniser for pins that arrive from outside the bus clock
// assumes the pins are quasi-static against hclk or tolerate one sample of skew
`timescale 1ns/1ps
`default_nettype none
module prs_pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // pins and their synchronised copies
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_q[i]  <= 1'b0;
                    pin_out[i] <= 1'b0;
                end else begin
                    meta_q[i]  <= pin_in[i];
                    pin_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- core/prs_pkg.sv
// constants, register map and state encoding of the pixel row gate sequencer
// assumes a single 50 MHz bus clock shared by every file of the block
package prs_pkg;
    // ****************************************
    // array geometry
    // ****************************************
    localparam int ROW_W = 11;
    localparam int COL_W = 11;
    localparam int PIX_W = 10;
    localparam int INT_W = 11;
    localparam int TIM_W = 8;
    localparam int PER_W = 13;
    localparam logic [ROW_W-1:0] ACTIVE_ROWS = 11'h400;
    localparam logic [COL_W-1:0] ACTIVE_COLS = 11'h500;
    localparam logic [PER_W-1:0] ROW_OVERHEAD = 13'h0013;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ROW_BEG = 8'h04;
    localparam logic [7:0] OFS_ROW_END = 8'h08;
    localparam logic [7:0] OFS_COL_BEG = 8'h0C;
    localparam logic [7:0] OFS_COL_END = 8'h10;
    localparam logic [7:0] OFS_VRD     = 8'h14;
    localparam logic [7:0] OFS_VCW     = 8'h18;
    localparam logic [7:0] OFS_SAMPLE  = 8'h1C;
    localparam logic [7:0] OFS_INTEG   = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;

    localparam int CTRL_MODE_BIT  = 6;
    localparam int SAMPLE_SHR_LSB = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [ROW_W-1:0] ROW_END_RST = 11'h3FF;
    localparam logic [COL_W-1:0] COL_END_RST = 11'h4FF;
    localparam logic [ROW_W-1:0] VRD_RST     = 11'h407;
    localparam logic [COL_W-1:0] VCW_RST     = 11'h4FF;
    localparam logic [TIM_W-1:0] SHS_RST     = 8'h10;
    localparam logic [TIM_W-1:0] SHR_RST     = 8'h10;
    localparam logic [INT_W-1:0] INTEG_RST   = 11'h100;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ****************************************
    // gate sequence steps
    // ****************************************
    typedef enum logic [3:0] {
        PRS_IDLE = 4'b0000,
        PRS_T0   = 4'b0001,
        PRS_T1   = 4'b0010,
        PRS_T2   = 4'b0011,
        PRS_T3   = 4'b0100,
        PRS_T4   = 4'b0101,
        PRS_T5   = 4'b0110,
        PRS_T5B  = 4'b0111,
        PRS_T6   = 4'b1000
    } prs_step_type;
endpackage

//--- core/prs_row_timer.sv
// row period counter: a row lasts virtual width + both sample times + overhead clocks
// assumes the period inputs change only between frames; a change mid-row lengthens or cuts short one row
`timescale 1ns/1ps
`default_nettype none
module prs_row_timer
    import prs_pkg::*;
(
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // period parameters
    input  wire logic [prs_pkg::COL_W-1:0] vcw,
    input  wire logic [prs_pkg::TIM_W-1:0] shs,
    input  wire logic [prs_pkg::TIM_W-1:0] shr,
    // position within the row and end of row
    output var  logic [prs_pkg::PER_W-1:0] col_pos,
    output var  logic                      row_tick
);
    logic [PER_W-1:0] period_m1;
    logic [PER_W-1:0] cnt_d;

    // one less than the period, so the count runs 0 .. period-1
    assign period_m1 = PER_W'(vcw) + PER_W'(shs) + PER_W'(shr) + ROW_OVERHEAD - PER_W'(1);
    assign row_tick  = (col_pos >= period_m1);
    assign cnt_d     = row_tick ? '0 : col_pos + PER_W'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col_pos <= '0;
        end else begin
            col_pos <= cnt_d;
        end
    end
endmodule
`default_nettype wire

//--- core/prs_top.sv
// pixel row gate sequencer: ahb-lite registers, pair-wise gate sequence, pixel stream out
// assumes a single ahb-lite master, whole-word transfers and an adc that delivers
// one 10-bit sample per clock on pins asynchronous to hclk
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - step zero raises both transfers and reset
// - step one drops transfer one
// - step two drops transfer two
// - step three drops reset before readout
// - step four reads first row
// - step five ends readout, reasserts reset
// - reset drops, step six reads second row
// - gate lines are common per row
// - row pairs share one diffusion node
// - control bit six picks capture mode
// - row and column window, down to 1x1
// - addresses 1280x1024 plus periphery pixels
// - ten-bit pixel words stream out
// - frame, line and pixel syncs accompany data
// - integration from one row to whole frame
// - frame rate set by registers in continuous mode
// - reset starts continuous rolling capture
// - single mode waits for sync each frame
// - row period is vcw+shs+shr+19 clocks
module prs_top
    import prs_pkg::*;
(
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output var  logic [31:0]               hrdata,
    output var  logic                      hreadyout,
    output var  logic                      hresp,
    // capture trigger and adc samples
    input  wire logic                      sync_pin,
    input  wire logic [prs_pkg::PIX_W-1:0] adc_data,
    // row gate lines of the addressed pair
    output var  logic [prs_pkg::ROW_W-1:0] row_addr,
    output var  logic                      rst_gate,
    output var  logic                      tx1_gate,
    output var  logic                      tx2_gate,
    output var  logic                      fd_gate,
    output var  logic                      rsel_gate,
    // pixel stream
    output var  logic [prs_pkg::PIX_W-1:0] pix_data,
    output var  logic                      pix_strobe,
    output var  logic                      line_valid,
    output var  logic                      frame_valid
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0]       ctrl_q;
    logic [ROW_W-1:0] row_beg_q, row_end_q, vrd_q;
    logic [COL_W-1:0] col_beg_q, col_end_q, vcw_q;
    logic [TIM_W-1:0] shs_q, shr_q;
    logic [INT_W-1:0] integ_q;
    logic [7:0]       frames_q;
    logic [7:0]       wr_ofs_q;
    logic             wr_pend_q;

    logic             mode_single;
    logic             addr_ok;
    logic             rd_go;
    logic             wr_go;
    logic [7:0]       ofs;
    logic [31:0]      rd_word;

    function automatic logic [31:0] pad(input logic [15:0] v);
        pad = {16'h0000, v};
    endfunction

    assign ofs         = haddr[7:0];
    assign addr_ok     = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_go       = addr_ok && !hwrite;
    assign wr_go       = addr_ok && hwrite;
    // a set mode bit means single-frame capture, cleared means continuous
    assign mode_single = ctrl_q[CTRL_MODE_BIT];

    prs_step_type     st_q, st_d;
    logic [ROW_W-1:0] pair_q;
    logic [INT_W-1:0] int_cnt_q;
    logic             pend_q;

    assign rd_word = (ofs == OFS_CTRL)    ? {24'h000000, ctrl_q} :
                     (ofs == OFS_ROW_BEG) ? pad(16'(row_beg_q)) :
                     (ofs == OFS_ROW_END) ? pad(16'(row_end_q)) :
                     (ofs == OFS_COL_BEG) ? pad(16'(col_beg_q)) :
                     (ofs == OFS_COL_END) ? pad(16'(col_end_q)) :
                     (ofs == OFS_VRD)     ? pad(16'(vrd_q)) :
                     (ofs == OFS_VCW)     ? pad(16'(vcw_q)) :
                     (ofs == OFS_SAMPLE)  ? pad({shr_q, shs_q}) :
                     (ofs == OFS_INTEG)   ? pad(16'(integ_q)) :
                     (ofs == OFS_STATUS)  ? {frames_q, 5'h00, pair_q, pend_q, 3'h0, st_q} :
                     32'h00000000;

    // zero wait states: read data latched at the address edge, writes at the data edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_ofs_q  <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= wr_go;
            wr_ofs_q  <= ofs;
            if (rd_go) begin
                hrdata <= rd_word;
            end
        end
    end

    // unmapped and read-only offsets ignore writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q    <= 8'h00;
            row_beg_q <= '0;
            row_end_q <= ROW_END_RST;
            col_beg_q <= '0;
            col_end_q <= COL_END_RST;
            vrd_q     <= VRD_RST;
            vcw_q     <= VCW_RST;
            shs_q     <= SHS_RST;
            shr_q     <= SHR_RST;
            integ_q   <= INTEG_RST;
        end else if (wr_pend_q) begin
            if (wr_ofs_q == OFS_CTRL) begin
                ctrl_q <= hwdata[7:0];
            end else if (wr_ofs_q == OFS_ROW_BEG) begin
                row_beg_q <= hwdata[ROW_W-1:0];
            end else if (wr_ofs_q == OFS_ROW_END) begin
                row_end_q <= hwdata[ROW_W-1:0];
            end else if (wr_ofs_q == OFS_COL_BEG) begin
                col_beg_q <= hwdata[COL_W-1:0];
            end else if (wr_ofs_q == OFS_COL_END) begin
                col_end_q <= hwdata[COL_W-1:0];
            end else if (wr_ofs_q == OFS_VRD) begin
                vrd_q <= hwdata[ROW_W-1:0];
            end else if (wr_ofs_q == OFS_VCW) begin
                vcw_q <= hwdata[COL_W-1:0];
            end else if (wr_ofs_q == OFS_SAMPLE) begin
                shs_q <= hwdata[TIM_W-1:0];
                shr_q <= hwdata[SAMPLE_SHR_LSB +: TIM_W];
            end else if (wr_ofs_q == OFS_INTEG) begin
                integ_q <= hwdata[INT_W-1:0];
            end
        end
    end

    // ****************************************
    // pins and row timing
    // ****************************************
    logic [PIX_W:0]   pins_s;
    logic             sync_s, sync_last_q, sync_rise;
    logic [PER_W-1:0] col_pos;
    logic             row_tick;

    prs_pin_sync #(.WIDTH(PIX_W + 1)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({sync_pin, adc_data}),
        .pin_out (pins_s)
    );

    prs_row_timer u_timer (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .vcw      (vcw_q),
        .shs      (shs_q),
        .shr      (shr_q),
        .col_pos  (col_pos),
        .row_tick (row_tick)
    );

    assign sync_s    = pins_s[PIX_W];
    assign sync_rise = sync_s && !sync_last_q;

    // ****************************************
    // gate sequencer, one row pair per pass
    // ****************************************
    logic last_pair;
    logic int_done;
    logic start_ok;
    logic frame_end;

    // both rows of a pair go through the shared node, first row then second
    assign last_pair = ({pair_q[ROW_W-2:0], 1'b1} >= vrd_q);
    assign int_done  = (int_cnt_q >= integ_q);
    assign start_ok  = mode_single ? pend_q : 1'b1;
    assign frame_end = row_tick && (st_q == PRS_T6) && last_pair;

    always_comb begin
        st_d = st_q;
        if (row_tick) begin
            case (st_q)
                PRS_IDLE: st_d = start_ok ? PRS_T0 : PRS_IDLE;
                PRS_T0:   st_d = PRS_T1;
                PRS_T1:   st_d = PRS_T2;
                PRS_T2:   st_d = int_done ? PRS_T3 : PRS_T2;
                PRS_T3:   st_d = PRS_T4;
                PRS_T4:   st_d = PRS_T5;
                PRS_T5:   st_d = PRS_T5B;
                PRS_T5B:  st_d = PRS_T6;
                PRS_T6:   st_d = (last_pair && mode_single) ? PRS_IDLE : PRS_T0;
                default:  st_d = PRS_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q        <= PRS_IDLE;
            pair_q      <= '0;
            int_cnt_q   <= '0;
            pend_q      <= 1'b0;
            sync_last_q <= 1'b0;
            frames_q    <= 8'h00;
        end else begin
            st_q        <= st_d;
            sync_last_q <= sync_s;
            // a sync arriving as the frame starts is kept for the next one
            pend_q      <= sync_rise || (pend_q && !(row_tick && st_q == PRS_IDLE));
            if (row_tick && st_q == PRS_T2) begin
                int_cnt_q <= int_cnt_q + INT_W'(1);
            end else if (st_q != PRS_T2) begin
                int_cnt_q <= '0;
            end
            if (row_tick && st_q == PRS_T6) begin
                pair_q <= last_pair ? '0 : pair_q + ROW_W'(1);
            end
            if (frame_end) begin
                frames_q <= frames_q + 8'h01;
            end
        end
    end

    // ****************************************
    // gate line decode, one line per row
    // ****************************************
    logic g_rst, g_tx1, g_tx2, g_fd, g_rsel, row_b;

    assign g_rst  = (st_q == PRS_T0) || (st_q == PRS_T1) || (st_q == PRS_T2) || (st_q == PRS_T5);
    assign g_tx1  = (st_q == PRS_T0) || (st_q == PRS_T4);
    assign g_tx2  = (st_q == PRS_T0) || (st_q == PRS_T1) || (st_q == PRS_T6);
    assign g_fd   = (st_q == PRS_T4) || (st_q == PRS_T6);
    assign g_rsel = g_fd;
    assign row_b  = (st_q == PRS_T5B) || (st_q == PRS_T6);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_gate  <= 1'b0;
            tx1_gate  <= 1'b0;
            tx2_gate  <= 1'b0;
            fd_gate   <= 1'b0;
            rsel_gate <= 1'b0;
            row_addr  <= '0;
        end else begin
            rst_gate  <= g_rst;
            tx1_gate  <= g_tx1;
            tx2_gate  <= g_tx2;
            fd_gate   <= g_fd;
            rsel_gate <= g_rsel;
            row_addr  <= {pair_q[ROW_W-2:0], row_b};
        end
    end

    // ****************************************
    // pixel stream and syncs
    // ****************************************
    logic [ROW_W-1:0] cur_row;
    logic             row_in_win, col_in_win, in_frame;

    // dark and dummy columns outside the window reach pix_data but never raise pix_strobe or line_valid
    assign cur_row    = {pair_q[ROW_W-2:0], row_b};
    assign row_in_win = (cur_row >= row_beg_q) && (cur_row <= row_end_q);
    assign col_in_win = (col_pos >= PER_W'(col_beg_q)) && (col_pos <= PER_W'(col_end_q));
    assign in_frame   = (st_q != PRS_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pix_data    <= '0;
            pix_strobe  <= 1'b0;
            line_valid  <= 1'b0;
            frame_valid <= 1'b0;
        end else begin
            pix_data    <= pins_s[PIX_W-1:0];
            pix_strobe  <= g_fd && row_in_win && col_in_win;
            line_valid  <= g_fd && row_in_win && col_in_win;
            frame_valid <= in_frame;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_step_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T0 |=> rst_gate && tx1_gate && tx2_gate && !rsel_gate)
        else $error("step zero gates wrong");
    a_tx1_release: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T1 |=> !tx1_gate && tx2_gate && rst_gate)
        else $error("step one gates wrong");
    a_tx2_release: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T2 |=> !tx2_gate && !tx1_gate && rst_gate)
        else $error("step two gates wrong");
    a_reset_release: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T3 |=> !rst_gate && !rsel_gate)
        else $error("step three gates wrong");
    a_row_a_read: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T4 |=> tx1_gate && fd_gate && rsel_gate && !row_addr[0])
        else $error("first row readout wrong");
    a_row_b_prep: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T5 |=> rst_gate && !fd_gate && !rsel_gate)
        else $error("second row preparation wrong");
    a_row_b_read: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_T6 |=> tx2_gate && fd_gate && rsel_gate && !rst_gate && row_addr[0])
        else $error("second row readout wrong");
    a_step_on_tick: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q != $past(st_q) |-> $past(row_tick))
        else $error("step changed off the row tick");
    a_single_waits: assert property (@(posedge hclk) disable iff (!hresetn)
        st_q == PRS_IDLE && mode_single && !pend_q && !sync_rise |=> st_q == PRS_IDLE)
        else $error("single mode started without sync");
    a_line_in_frame: assert property (@(posedge hclk) disable iff (!hresetn)
        line_valid |-> frame_valid && pix_strobe)
        else $error("line valid outside frame");
endmodule
`default_nettype wire

//--- verif/prs_video_rx.sv
// video receiver model: counts and keeps the window pixels of the stream
// assumes the stream outputs change just after rising hclk
`timescale 1ns/1ps
`default_nettype none
module prs_video_rx
    import prs_pkg::*;
(
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // pixel stream
    input  wire logic                      frame_valid,
    input  wire logic                      line_valid,
    input  wire logic                      pix_strobe,
    input  wire logic [prs_pkg::PIX_W-1:0] pix_data,
    // kept pixels
    output var  logic [15:0]               taken_q,
    output var  logic [prs_pkg::PIX_W-1:0] last_q
);
    // ****************
    // intake
    // ****************
    // words outside a valid line are blanking or dummy pixels and are never kept
    wire logic keep = frame_valid & line_valid & pix_strobe;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            taken_q <= 16'h0000;
            last_q  <= 10'h000;
        end else if (keep) begin
            taken_q <= taken_q + 16'h0001;
            last_q  <= pix_data;
        end
    end
endmodule
`default_nettype wire

//--- verif/tb.sv
// bench of the row gate sequencer: registers, gate steps, pixel stream, capture modes
// assumes the receiver model on the stream and hready looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module tb;
    import prs_pkg::*;
    // ****************
    // signals
    // ****************
    localparam logic [4:0] STEP_GATES [8] = '{5'h1C, 5'h14, 5'h10, 5'h00, 5'h0B, 5'h10, 5'h00, 5'h07};
    logic             hclk, hresetn, hsel, hwrite, sync_pin;
    logic [31:0]      haddr, hwdata, hrdata, rd, rnd;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic             hreadyout, hresp, pix_strobe, line_valid, frame_valid;
    logic             rst_gate, tx1_gate, tx2_gate, fd_gate, rsel_gate;
    logic [PIX_W-1:0] adc_data, pix_data, adc_hist [3];
    logic [PIX_W-1:0] last_pix, exp_last;
    logic [ROW_W-1:0] row_addr;
    logic [15:0]      taken;
    int               failures, cmp_count, integ, rb, re, cb, ce, n;
    wire logic [4:0]  gates = {rst_gate, tx1_gate, tx2_gate, fd_gate, rsel_gate};

    prs_top u_prs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sync_pin(sync_pin), .adc_data(adc_data),
        .row_addr(row_addr), .rst_gate(rst_gate), .tx1_gate(tx1_gate), .tx2_gate(tx2_gate),
        .fd_gate(fd_gate), .rsel_gate(rsel_gate), .pix_data(pix_data), .pix_strobe(pix_strobe),
        .line_valid(line_valid), .frame_valid(frame_valid));
    prs_video_rx u_prs_video_rx (.hclk(hclk), .hresetn(hresetn), .frame_valid(frame_valid),
        .line_valid(line_valid), .pix_strobe(pix_strobe), .pix_data(pix_data), .taken_q(taken),
        .last_q(last_pix));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // history lines up with the three-clock pixel delay when read at the falling edge
    always @(posedge hclk) begin
        rnd      <= xorshift(rnd);
        adc_data <= rnd[PIX_W-1:0];
        adc_hist <= '{adc_data, adc_hist[0], adc_hist[1]};
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int exp_dur(input int s);
        return (s == 2) ? (integ + 1) * int'(ROW_OVERHEAD) : int'(ROW_OVERHEAD);
    endfunction
    function automatic int exp_pix(input int row);
        return (row >= rb && row <= re) ? ce - cb + 1 : 0;
    endfunction

    // ****************
    // checks and bus
    // ****************
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_num(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            failures++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_val("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wait_t0;
        logic [4:0] prev;
        n = 0;
        do begin
            prev = gates;
            @(negedge hclk);
            n++;
        // a frame opens on pair zero; a pass that began while setup was still running is skipped
        end while (!(gates === STEP_GATES[0] && prev !== STEP_GATES[0] && row_addr === '0) && n < 20000);
    endtask
    task automatic walk(input int nsteps, input int vrd);
        int s, dur, pair, row;
        logic [15:0] t0;
        s = 0;
        pair = 0;
        repeat (nsteps) begin
            dur = 0;
            t0 = taken;
            row = 2 * pair + (s == 7);
            chk_val("gates", STEP_GATES[s], gates);
            chk_val("frame_valid", 32'h1, frame_valid);
            if (s == 4 || s == 7) chk_val("row_addr", row, row_addr);
            while (gates === STEP_GATES[s] && dur < 4000) begin
                if (pix_strobe === 1'b1) begin
                    chk_val("pix_data", adc_hist[2], pix_data);
                    exp_last = adc_hist[2];
                end
                @(negedge hclk);
                dur++;
            end
            chk_num("step_len", exp_dur(s), dur);
            if (s == 4 || s == 7) chk_num("pix_count", exp_pix(row), 16'(taken - t0));
            if (taken != t0) chk_val("last_pix", exp_last, last_pix);
            if (s == 7) pair = (row >= vrd) ? 0 : pair + 1;
            s = (s + 1) % 8;
        end
    endtask
    task automatic idle_check;
        int busy;
        busy = 0;
        repeat (3) @(negedge hclk);
        repeat (200) begin
            if (frame_valid !== 1'b0 || gates !== 5'h00) busy++;
            @(negedge hclk);
        end
        chk_num("idle_hold", 0, busy);
    endtask
    task tally_and_finish;
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        failures++;
        tally_and_finish();
    end
    initial begin
        logic [7:0]  offs [10];
        logic [7:0]  cfg_ofs [8];
        logic [31:0] rvals [10];
        logic [31:0] cfg_val [8];
        {hresetn, hsel, hwrite, sync_pin, htrans, hsize} = {4'h0, 2'h0, 3'h2};
        {haddr, hwdata, adc_data} = '0;
        rnd = 32'h000161E3;
        integ = int'(xorshift(32'h000161E3) % 32'h3) + 1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        offs = '{OFS_CTRL, OFS_ROW_BEG, OFS_ROW_END, OFS_COL_BEG, OFS_COL_END, OFS_VRD, OFS_VCW,
            OFS_SAMPLE, OFS_INTEG, 8'h40};
        rvals = '{0, 0, ROW_END_RST, 0, COL_END_RST, VRD_RST, VCW_RST, {SHR_RST, SHS_RST}, INTEG_RST, 0};
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk_val("reset_value", rvals[i], rd);
        end
        bus(1'b1, OFS_COL_BEG, 32'hFFFFFFFF);
        bus(1'b0, OFS_COL_BEG, 32'h0);
        chk_val("col_beg_width", 32'h7FF, rd);
        cfg_ofs = '{OFS_VCW, OFS_SAMPLE, OFS_INTEG, OFS_VRD, OFS_ROW_BEG, OFS_ROW_END, OFS_COL_BEG, OFS_COL_END};
        cfg_val = '{0, 0, integ, 3, 0, 3, 2, 5};
        {rb, re, cb, ce} = {32'd0, 32'd3, 32'd2, 32'd5};
        for (int i = 0; i < 8; i++) bus(1'b1, cfg_ofs[i], cfg_val[i]);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, cfg_ofs[i], 32'h0);
            chk_val("config", cfg_val[i], rd);
        end
        wait_t0();
        chk_num("first_frame", 1, n < 20000);
        walk(16, 3);
        // narrow to a single pixel while the next frame runs
        fork
            walk(16, 3);
            begin
                bus(1'b1, OFS_ROW_BEG, 32'h1);
                bus(1'b1, OFS_ROW_END, 32'h1);
                bus(1'b1, OFS_COL_BEG, 32'h3);
                bus(1'b1, OFS_COL_END, 32'h3);
                {rb, re, cb, ce} = {32'd1, 32'd1, 32'd3, 32'd3};
            end
        join
        fork
            walk(16, 3);
            bus(1'b1, OFS_CTRL, 32'h1 << CTRL_MODE_BIT);
        join
        idle_check();
        repeat (2) begin
            @(posedge hclk);
            sync_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            sync_pin <= 1'b0;
            wait_t0();
            chk_num("sync_start", 1, n < 40);
            walk(16, 3);
            idle_check();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
